//--- hdl/usb_device_endpoint_command_unit.v
`timescale 1ns/1ps
`include "usb_cmd_regs.vh"
module usb_device_endpoint_command_unit #(
   parameter NUM_EP         = 6,
   parameter EP_W           = 3,
   parameter PTR_W          = 6,
   parameter [5:0] OUT_MASK = 6'h05,
   parameter CNT_W          = 20,
   parameter SUSPEND_CYCLES = `SUSPEND_MS * 1000 * `CLOCK_MHZ
) (
   input  wire              clock,
   input  wire              reset,
   input  wire              cmd_valid,
   input  wire [7:0]        cmd_code,
   input  wire              data_wr_valid,
   input  wire [7:0]        data_wr,
   input  wire              data_rd_req,
   output wire              data_rd_req_ready,
   output wire              rd_valid,
   output wire [7:0]        rd_data,
   input  wire              rd_ready,
   input  wire              bus_activity,
   input  wire              bus_reset_event,
   input  wire              error_valid,
   input  wire [3:0]        error_code,
   input  wire              new_transfer,
   input  wire              rx_ok,
   input  wire [EP_W-1:0]   rx_ep,
   input  wire              rx_setup,
   input  wire              tx_ack,
   input  wire [EP_W-1:0]   tx_ep,
   output reg               remote_wakeup,
   output reg  [6:0]        func_address,
   output reg               func_enable,
   output wire [NUM_EP-1:0] ep_full,
   output wire [NUM_EP-1:0] ep_stall,
   output wire [NUM_EP-1:0] ep_disable,
   output wire [NUM_EP-1:0] ep_rate_feedback,
   output wire [NUM_EP-1:0] ep_event,
   output wire [NUM_EP-1:0] ep_nak
);
   localparam [8:0] ST_IDLE  = 9'h001;
   localparam [8:0] ST_SEL   = 9'h002;
   localparam [8:0] ST_SETST = 9'h004;
   localparam [8:0] ST_RDBUF = 9'h008;
   localparam [8:0] ST_WRBUF = 9'h010;
   localparam [8:0] ST_CLR   = 9'h020;
   localparam [8:0] ST_DEVST = 9'h040;
   localparam [8:0] ST_ERR   = 9'h080;
   localparam [8:0] ST_ADDR  = 9'h100;
   localparam [7:0] NUM_EP_B = NUM_EP[7:0];
   localparam [CNT_W-1:0] SUSP_LIMIT = SUSPEND_CYCLES[CNT_W-1:0];

   reg  [8:0]        st;
   reg  [8:0]        next_st;
   reg  [EP_W-1:0]   sel_ep;
   reg  [EP_W-1:0]   tgt_ep;
   reg  [PTR_W-1:0]  ptr;
   reg  [CNT_W-1:0]  idle_cnt;
   reg               suspend;
   reg               suspend_d;
   reg               susp_change;
   reg               bus_rst_flag;
   reg  [4:0]        err_reg;
   reg               ovwr_snap;
   reg               rd_pending;
   reg               pend_mem;
   reg  [7:0]        pend_byte;
   reg  [7:0]        next_byte;
   reg  [7:0]        fifo0;
   reg  [7:0]        fifo1;
   reg  [1:0]        fifo_count;
   reg  [7:0]        dev_byte;
   reg  [7:0]        ep_byte;
   wire [7:0]        mem_q;
   wire [7:0]        push_byte;
   wire [NUM_EP-1:0] ep_setup;
   wire [NUM_EP-1:0] ep_ovwr;
   wire              rd_take;
   wire              push;
   wire              pop;
   wire              is_sel;
   wire              is_sel_clr;
   wire              is_set_st;
   wire              cmd_sel;
   wire              cmd_sel_clr;
   wire              cmd_clear;
   wire              cmd_validate;
   wire              wr_set_st;
   wire              mem_we;
   wire              mem_re;
   wire [EP_W-1:0]   cmd_ep;

   // Command decode; bases are multiples of eight so the low bits give the end-point
   assign is_sel       = cmd_code < NUM_EP_B;
   assign is_sel_clr   = (cmd_code >= `CMD_SEL_CLR_BASE) && (cmd_code < `CMD_SEL_CLR_BASE + NUM_EP_B);
   assign is_set_st    = (cmd_code >= `CMD_SET_STATUS_BASE) && (cmd_code < `CMD_SET_STATUS_BASE + NUM_EP_B);
   assign cmd_ep       = cmd_code[EP_W-1:0];
   assign cmd_sel      = cmd_valid && is_sel;
   assign cmd_sel_clr  = cmd_valid && is_sel_clr;
   assign cmd_clear    = cmd_valid && (cmd_code == `CMD_CLEAR_BUF);
   assign cmd_validate = cmd_valid && (cmd_code == `CMD_VALIDATE_BUF);
   assign wr_set_st    = data_wr_valid && st[2];

   // Read requests only taken while the output buffer has room for the answer
   assign data_rd_req_ready = (fifo_count + {1'b0, rd_pending}) < `RD_BUF_DEPTH;
   assign rd_take           = data_rd_req && data_rd_req_ready;
   assign mem_re            = rd_take && st[3];
   assign mem_we            = data_wr_valid && st[4];

   // Phase of the data transfers that follow each command byte
   always @* begin
      next_st = st;
      if (cmd_valid) begin
         if (is_sel || is_sel_clr) begin
            next_st = ST_SEL;
         end else if (is_set_st) begin
            next_st = ST_SETST;
         end else begin
            case (cmd_code)
               `CMD_READ_BUF:    next_st = ST_RDBUF;
               `CMD_WRITE_BUF:   next_st = ST_WRBUF;
               `CMD_CLEAR_BUF:   next_st = ST_CLR;
               `CMD_DEV_STATUS:  next_st = ST_DEVST;
               `CMD_ERROR_CODE:  next_st = ST_ERR;
               `CMD_SET_ADDRESS: next_st = ST_ADDR;
               default:          next_st = ST_IDLE;
            endcase
         end
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         st     <= ST_IDLE;
         sel_ep <= {EP_W{1'b0}};
         tgt_ep <= {EP_W{1'b0}};
         ptr    <= {PTR_W{1'b0}};
      end else begin
         st <= next_st;
         if (cmd_sel || cmd_sel_clr) begin
            sel_ep <= cmd_ep;
            ptr    <= {PTR_W{1'b0}};
         end else if (mem_re || mem_we) begin
            ptr <= ptr + {{(PTR_W-1){1'b0}}, 1'b1};
         end
         if (cmd_valid && is_set_st) begin
            tgt_ep <= cmd_ep;
         end
      end
   end

   // Suspend detection from upstream idle time
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         idle_cnt  <= {CNT_W{1'b0}};
         suspend   <= 1'b0;
         suspend_d <= 1'b0;
      end else begin
         suspend_d <= suspend;
         if (bus_activity) begin
            idle_cnt <= {CNT_W{1'b0}};
            suspend  <= 1'b0;
         end else if (idle_cnt != SUSP_LIMIT) begin
            idle_cnt <= idle_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end else begin
            suspend <= 1'b1;
         end
      end
   end

   // Device status flags; a new event wins over the clear by read
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         susp_change   <= 1'b0;
         bus_rst_flag  <= 1'b0;
         remote_wakeup <= 1'b0;
         func_address  <= `ADDR_RESET;
         func_enable   <= 1'b0;
      end else begin
         remote_wakeup <= data_wr_valid && st[6] && !data_wr[`DS_SUSPEND] && suspend;
         if (rd_take && st[6]) begin
            susp_change  <= 1'b0;
            bus_rst_flag <= 1'b0;
         end
         if (suspend != suspend_d) begin
            susp_change <= 1'b1;
         end
         if (data_wr_valid && st[8]) begin
            func_address <= data_wr[6:0];
            func_enable  <= data_wr[`ADDR_ENABLE];
         end
         if (bus_reset_event) begin
            bus_rst_flag <= 1'b1;
            func_address <= `ADDR_RESET;
            func_enable  <= 1'b1;
         end
      end
   end

   // Last error code and error-occurred flag
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         err_reg <= `ERR_RESET;
      end else if (error_valid) begin
         err_reg <= {1'b1, error_code};
      end else if (new_transfer) begin
         err_reg[`ERR_FLAG] <= 1'b0;
      end
   end

   always @* begin
      dev_byte                  = 8'h00;
      dev_byte[`DS_SUSPEND]     = suspend;
      dev_byte[`DS_SUSP_CHANGE] = susp_change;
      dev_byte[`DS_BUS_RESET]   = bus_rst_flag;
      ep_byte                   = 8'h00;
      ep_byte[`EPS_FULL]        = ep_full[sel_ep];
      ep_byte[`EPS_STALL]       = ep_stall[sel_ep];
      ep_byte[`EPS_SETUP]       = ep_setup[sel_ep];
      ep_byte[`EPS_OVERWRITTEN] = ep_ovwr[sel_ep];
      case (st)
         ST_SEL:   next_byte = ep_byte;
         ST_CLR:   next_byte = {7'h00, ovwr_snap};
         ST_DEVST: next_byte = dev_byte;
         ST_ERR:   next_byte = {3'h0, err_reg};
         default:  next_byte = 8'h00;
      endcase
   end

   // One answer in flight, then into the two-entry output buffer
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_pending <= 1'b0;
         pend_mem   <= 1'b0;
         pend_byte  <= 8'h00;
         ovwr_snap  <= 1'b0;
      end else begin
         rd_pending <= rd_take;
         pend_mem   <= mem_re;
         if (rd_take) begin
            pend_byte <= next_byte;
         end
         if (cmd_clear) begin
            ovwr_snap <= ep_ovwr[sel_ep];
         end
      end
   end

   assign push_byte = pend_mem ? mem_q : pend_byte;
   assign push      = rd_pending;
   assign pop       = rd_valid && rd_ready;
   assign rd_valid  = fifo_count != 2'h0;
   assign rd_data   = fifo0;

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         fifo0      <= 8'h00;
         fifo1      <= 8'h00;
         fifo_count <= 2'h0;
      end else begin
         if (push && pop) begin
            if (fifo_count == 2'h1) begin
               fifo0 <= push_byte;
            end else begin
               fifo0 <= fifo1;
               fifo1 <= push_byte;
            end
         end else if (push) begin
            if (fifo_count == 2'h0) begin
               fifo0 <= push_byte;
            end else begin
               fifo1 <= push_byte;
            end
            fifo_count <= fifo_count + 2'h1;
         end else if (pop) begin
            fifo0      <= fifo1;
            fifo_count <= fifo_count - 2'h1;
         end
      end
   end

   // Per end-point state
   genvar i;
   generate
      for (i = 0; i < NUM_EP; i = i + 1) begin : g_ep
         reg  full_r;
         reg  stall_r;
         reg  setup_r;
         reg  ovwr_r;
         reg  event_r;
         reg  disable_r;
         reg  ratefb_r;
         reg  cond_r;
         wire is_out = OUT_MASK[i];
         wire on_sel = sel_ep == i;
         wire on_rx  = rx_ok && (rx_ep == i);
         assign ep_full[i]          = full_r;
         assign ep_setup[i]         = setup_r;
         assign ep_ovwr[i]          = ovwr_r;
         assign ep_event[i]         = event_r;
         assign ep_disable[i]       = disable_r;
         assign ep_rate_feedback[i] = ratefb_r;
         assign ep_stall[i]         = stall_r || (cond_r && !ep_setup[0]);
         assign ep_nak[i]           = is_out ? full_r : !full_r;
         always @(posedge clock or posedge reset) begin
            if (reset) begin
               full_r    <= 1'b0;
               stall_r   <= 1'b0;
               setup_r   <= 1'b0;
               ovwr_r    <= 1'b0;
               event_r   <= 1'b0;
               disable_r <= 1'b0;
               ratefb_r  <= 1'b0;
               cond_r    <= 1'b0;
            end else if (bus_reset_event) begin
               full_r    <= 1'b0;
               stall_r   <= 1'b0;
               setup_r   <= 1'b0;
               ovwr_r    <= 1'b0;
               event_r   <= 1'b0;
               disable_r <= 1'b0;
               cond_r    <= 1'b0;
            end else begin
               if (cmd_sel && cmd_ep == i) begin
                  ovwr_r <= 1'b0;
               end
               if (cmd_sel_clr && cmd_ep == i) begin
                  event_r <= 1'b0;
                  if (i == 0) begin
                     setup_r <= 1'b0;
                     ovwr_r  <= 1'b0;
                  end
               end
               if (cmd_clear && on_sel && is_out && !ovwr_r) begin
                  full_r <= 1'b0;
               end
               if (cmd_validate && on_sel && !is_out && !(i == 1 && ep_ovwr[0])) begin
                  full_r <= 1'b1;
               end
               if (wr_set_st && tgt_ep == i) begin
                  stall_r <= data_wr[`SET_STALL];
                  full_r  <= 1'b0;
                  if (i >= 2) begin
                     disable_r <= data_wr[`SET_DISABLE];
                     ratefb_r  <= data_wr[`SET_RATE_FEEDBACK];
                  end else begin
                     cond_r <= data_wr[`SET_BIT7];
                  end
               end
               if (tx_ack && tx_ep == i && !is_out) begin
                  full_r  <= 1'b0;
                  event_r <= 1'b1;
               end
               if (on_rx && is_out) begin
                  if (!full_r) begin
                     full_r  <= 1'b1;
                     setup_r <= rx_setup;
                     event_r <= 1'b1;
                  end else if (rx_setup && i == 0) begin
                     ovwr_r  <= 1'b1;
                     setup_r <= 1'b1;
                     event_r <= 1'b1;
                  end
                  if (rx_setup && i < 2) begin
                     stall_r <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate

   usb_ep_buffer_ram #(
      .AW(EP_W + PTR_W),
      .DW(8)
   ) u_ram (
      .clock        (clock),
      .reset        (reset),
      .write_enable (mem_we),
      .read_enable  (mem_re),
      .address      ({sel_ep, ptr}),
      .write_data   (data_wr),
      .read_data    (mem_q)
   );
endmodule

//--- hdl/usb_ep_buffer_ram.v
`timescale 1ns/1ps
module usb_ep_buffer_ram #(
   parameter AW = 9,
   parameter DW = 8
) (
   input  wire          clock,
   input  wire          reset,
   input  wire          write_enable,
   input  wire          read_enable,
   input  wire [AW-1:0] address,
   input  wire [DW-1:0] write_data,
   output reg  [DW-1:0] read_data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clock) begin
      if (write_enable) begin
         mem[address] <= write_data;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         read_data <= {DW{1'b0}};
      end else if (read_enable) begin
         read_data <= mem[address];
      end
   end
endmodule

//--- include/usb_cmd_regs.vh
`ifndef USB_CMD_REGS_VH
`define USB_CMD_REGS_VH
`define CMD_SEL_BASE        8'h00
`define CMD_SEL_CLR_BASE    8'h20
`define CMD_SET_STATUS_BASE 8'h40
`define CMD_SET_ADDRESS     8'hD0
`define CMD_READ_BUF        8'hF0
`define CMD_WRITE_BUF       8'hF1
`define CMD_CLEAR_BUF       8'hF2
`define CMD_VALIDATE_BUF    8'hFA
`define CMD_DEV_STATUS      8'hFE
`define CMD_ERROR_CODE      8'hFF
`define DS_SUSPEND          2
`define DS_SUSP_CHANGE      3
`define DS_BUS_RESET        4
`define ERR_FLAG            4
`define EPS_FULL            0
`define EPS_STALL           1
`define EPS_SETUP           2
`define EPS_OVERWRITTEN     3
`define SET_STALL           0
`define SET_DISABLE         5
`define SET_RATE_FEEDBACK   6
`define SET_BIT7            7
`define CLR_OVERWRITTEN     0
`define ADDR_ENABLE         7
`define ADDR_RESET          7'h00
`define ERR_RESET           5'h00
`define ERR_NONE            4'h0
`define ERR_PID_ENCODING    4'h1
`define ERR_UNKNOWN_PID     4'h2
`define ERR_UNEXPECTED      4'h3
`define ERR_TOKEN_CRC       4'h4
`define ERR_DATA_CRC        4'h5
`define ERR_TIMEOUT         4'h6
`define ERR_BABBLE          4'h7
`define ERR_END_OF_PACKET   4'h8
`define ERR_SENT_NAK        4'h9
`define ERR_SENT_STALL      4'hA
`define ERR_OVERRUN         4'hB
`define ERR_RESERVED        4'hC
`define ERR_BITSTUFF        4'hD
`define ERR_SYNC            4'hE
`define ERR_WRONG_TOGGLE    4'hF
`define SUSPEND_MS          3
`define CLOCK_MHZ           200
`define RD_BUF_DEPTH        2'h2
`endif

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "usb_cmd_regs.vh"
module tb_top;
   reg         clock = 1'b0;
   reg         reset = 1'b1;
   reg         cmd_valid = 1'b0;
   reg  [7:0]  cmd_code = 8'h00;
   reg         data_wr_valid = 1'b0;
   reg  [7:0]  data_wr = 8'h00;
   reg         data_rd_req = 1'b0;
   reg         rd_ready = 1'b0;
   wire        data_rd_req_ready, rd_valid, remote_wakeup, func_enable;
   wire        bus_activity, bus_reset_event, error_valid, new_transfer, rx_ok, rx_setup, tx_ack;
   wire [7:0]  rd_data;
   wire [6:0]  func_address;
   wire [3:0]  error_code;
   wire [2:0]  rx_ep, tx_ep;
   wire [5:0]  ep_full, ep_stall, ep_disable, ep_rate_feedback, ep_event, ep_nak;
   integer     num_errors = 0;
   integer     compares = 0;
   integer     i;
   reg  [7:0]  v;
   always #2.5 clock = ~clock;
   usb_device_endpoint_command_unit #(.SUSPEND_CYCLES(20)) i_usb_device_endpoint_command_unit (
      .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .data_wr_valid(data_wr_valid), .data_wr(data_wr), .data_rd_req(data_rd_req),
      .data_rd_req_ready(data_rd_req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
      .bus_activity(bus_activity), .bus_reset_event(bus_reset_event), .error_valid(error_valid),
      .error_code(error_code), .new_transfer(new_transfer), .rx_ok(rx_ok), .rx_ep(rx_ep),
      .rx_setup(rx_setup), .tx_ack(tx_ack), .tx_ep(tx_ep), .remote_wakeup(remote_wakeup),
      .func_address(func_address), .func_enable(func_enable), .ep_full(ep_full), .ep_stall(ep_stall),
      .ep_disable(ep_disable), .ep_rate_feedback(ep_rate_feedback), .ep_event(ep_event), .ep_nak(ep_nak)
   );
   usb_host_model i_usb_host_model (
      .clock(clock), .bus_activity(bus_activity), .bus_reset_event(bus_reset_event),
      .error_valid(error_valid), .error_code(error_code), .new_transfer(new_transfer), .rx_ok(rx_ok),
      .rx_ep(rx_ep), .rx_setup(rx_setup), .tx_ack(tx_ack), .tx_ep(tx_ep)
   );
   task check(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task cmd(input [7:0] c);
      begin
         @(posedge clock);
         #1 cmd_valid = 1'b1;
         cmd_code = c;
         @(posedge clock);
         #1 cmd_valid = 1'b0;
      end
   endtask
   task wr(input [7:0] d);
      begin
         @(posedge clock);
         #1 data_wr_valid = 1'b1;
         data_wr = d;
         @(posedge clock);
         #1 data_wr_valid = 1'b0;
      end
   endtask
   task rd(output [7:0] d);
      integer n;
      begin
         n = 0;
         @(posedge clock);
         #1 data_rd_req = 1'b1;
         while (!data_rd_req_ready && n < 50) begin
            @(posedge clock);
            #1 n = n + 1;
         end
         @(posedge clock);
         #1 data_rd_req = 1'b0;
         while (!rd_valid && n < 50) begin
            @(posedge clock);
            #1 n = n + 1;
         end
         if (n >= 50) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t read timed out", $time);
         end
         d = rd_data;
         rd_ready = 1'b1;
         @(posedge clock);
         #1 rd_ready = 1'b0;
      end
   endtask
   task crd(input [7:0] c, input [7:0] exp);
      begin
         cmd(c);
         rd(v);
         check(v, exp);
      end
   endtask
   task done(input integer t);
      $display("test %0d finished", t);
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", compares, num_errors);
         if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      #200000;
      num_errors = num_errors + 1;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize;
   end
   initial begin
      repeat (16) @(posedge clock);
      #1 reset = 1'b0;
      check(func_enable, 8'h00);
      check(ep_nak, 8'h3A);
      repeat (25) @(posedge clock);
      crd(`CMD_DEV_STATUS, 8'h0C);
      crd(`CMD_DEV_STATUS, 8'h04);
      wr(8'h04);
      check(remote_wakeup, 8'h00);
      wr(8'h00);
      check(remote_wakeup, 8'h01);
      i_usb_host_model.ev(4'h0, 4'h0, 3'h0);
      crd(`CMD_DEV_STATUS, 8'h08);
      done(1);
      cmd(`CMD_SET_ADDRESS);
      wr(8'h85);
      i_usb_host_model.ev(4'h1, 4'h0, 3'h0);
      check({func_enable, func_address}, 8'h80);
      crd(`CMD_DEV_STATUS, 8'h10);
      crd(`CMD_DEV_STATUS, 8'h00);
      crd(`CMD_ERROR_CODE, 8'h00);
      for (i = 0; i < 16; i = i + 1) begin
         i_usb_host_model.ev(4'h2, i[3:0], 3'h0);
         crd(`CMD_ERROR_CODE, {4'h1, i[3:0]});
         i_usb_host_model.ev(4'h3, 4'h0, 3'h0);
         crd(`CMD_ERROR_CODE, {4'h0, i[3:0]});
      end
      done(2);
      cmd(8'h03);
      cmd(`CMD_WRITE_BUF);
      for (i = 0; i < 3; i = i + 1) wr(8'hA1 + i[7:0]);
      cmd(`CMD_ERROR_CODE);
      cmd(`CMD_WRITE_BUF);
      wr(8'hA4);
      cmd(8'h03);
      for (i = 0; i < 4; i = i + 1) begin
         if (i == 2) cmd(`CMD_DEV_STATUS);
         if (i % 2 == 0) cmd(`CMD_READ_BUF);
         rd(v);
         check(v, 8'hA1 + i[7:0]);
      end
      cmd(`CMD_VALIDATE_BUF);
      check({ep_full[3], ep_nak[3]}, 8'h02);
      crd(8'h03, 8'h01);
      cmd(8'h03);
      cmd(`CMD_READ_BUF);
      @(posedge clock);
      #1 data_rd_req = 1'b1;
      repeat (4) @(posedge clock);
      #1 check(data_rd_req_ready, 8'h00);
      data_rd_req = 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
         check(rd_valid, 8'h01);
         check(rd_data, 8'hA1 + i[7:0]);
         rd_ready = 1'b1;
         @(posedge clock);
         #1 rd_ready = 1'b0;
      end
      check(rd_valid, 8'h00);
      i_usb_host_model.ev(4'h5, 4'h0, 3'h3);
      check(ep_nak[3], 8'h01);
      done(3);
      i_usb_host_model.ev(4'h4, 4'h0, 3'h2);
      i_usb_host_model.ev(4'h4, 4'h0, 3'h2);
      check({ep_full[2], ep_nak[2]}, 8'h03);
      cmd(8'h02);
      crd(`CMD_CLEAR_BUF, 8'h00);
      check(ep_full[2], 8'h00);
      i_usb_host_model.ev(4'h4, 4'h0, 3'h2);
      check(ep_full[2], 8'h01);
      cmd(8'h00);
      i_usb_host_model.ev(4'h4, 4'h0, 3'h0);
      i_usb_host_model.ev(4'h4, 4'h1, 3'h0);
      crd(`CMD_CLEAR_BUF, 8'h01);
      check(ep_full[0], 8'h01);
      check(ep_event[0], 8'h01);
      cmd(8'h01);
      cmd(`CMD_VALIDATE_BUF);
      check(ep_full[1], 8'h00);
      cmd(`CMD_SEL_CLR_BASE);
      rd(v);
      check(v, 8'h01);
      check(ep_event[0], 8'h00);
      cmd(`CMD_CLEAR_BUF);
      check(ep_full[0], 8'h00);
      cmd(8'h01);
      cmd(`CMD_VALIDATE_BUF);
      check(ep_full[1], 8'h01);
      done(4);
      cmd(8'h42);
      wr(8'h01);
      check(ep_stall[2], 8'h01);
      cmd(8'h43);
      wr(8'h20);
      check(ep_disable[3], 8'h01);
      cmd(8'h40);
      wr(8'h20);
      check(ep_disable[0], 8'h00);
      cmd(8'h45);
      wr(8'h40);
      check(ep_rate_feedback[5], 8'h01);
      cmd(8'h42);
      wr(8'h00);
      check(ep_stall[2], 8'h00);
      done(5);
      summarize;
   end
endmodule

//--- verification/usb_cmd_unit_chk.sv
`timescale 1ns/1ps
module usb_cmd_unit_chk #(
   parameter NUM_EP         = 6,
   parameter EP_W           = 3,
   parameter SUSPEND_CYCLES = 20
) (
   input wire              clock,
   input wire              reset,
   input wire              cmd_valid,
   input wire              data_wr_valid,
   input wire              data_rd_req,
   input wire              data_rd_req_ready,
   input wire              rd_valid,
   input wire [7:0]        rd_data,
   input wire              rd_ready,
   input wire              bus_activity,
   input wire              bus_reset_event,
   input wire              rx_ok,
   input wire [EP_W-1:0]   rx_ep,
   input wire              remote_wakeup,
   input wire [6:0]        func_address,
   input wire              func_enable,
   input wire [NUM_EP-1:0] ep_full,
   input wire [NUM_EP-1:0] ep_stall,
   input wire [NUM_EP-1:0] ep_disable,
   input wire [NUM_EP-1:0] ep_nak
);
   integer idle_cnt;
   // Cycles since the last upstream activity, saturating
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         idle_cnt <= 0;
      end else if (bus_activity) begin
         idle_cnt <= 0;
      end else if (idle_cnt < SUSPEND_CYCLES + 4) begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   property p_addr_reset;
      bus_reset_event && !data_wr_valid |=> func_address == 7'h00 && func_enable;
   endproperty
   a_addr_reset: assert property (p_addr_reset) else $error("address not defaulted by bus reset");
   property p_full_set;
      rx_ok && rx_ep == 2 && func_enable && !ep_full[2] && !ep_stall[2] && !ep_disable[2] && !bus_reset_event
         |=> ep_full[2];
   endproperty
   a_full_set: assert property (p_full_set) else $error("good packet did not fill buffer");
   property p_full_hold;
      ep_full[2] && !cmd_valid && !data_wr_valid && !bus_reset_event |=> ep_full[2];
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full flag dropped without clear");
   property p_out_nak;
      ep_nak[2] == ep_full[2];
   endproperty
   a_out_nak: assert property (p_out_nak) else $error("output nak differs from full");
   property p_in_nak;
      ep_nak[3] == !ep_full[3];
   endproperty
   a_in_nak: assert property (p_in_nak) else $error("input nak differs from empty");
   property p_rd_lat;
      data_rd_req && data_rd_req_ready |-> ##[1:3] rd_valid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read byte late");
   property p_rd_hold;
      rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("stalled read byte lost");
   property p_wake_pulse;
      remote_wakeup |=> !remote_wakeup;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake-up longer than one cycle");
   property p_wake_susp;
      remote_wakeup |-> idle_cnt >= SUSPEND_CYCLES;
   endproperty
   a_wake_susp: assert property (p_wake_susp) else $error("wake-up while not suspended");
endmodule
bind usb_device_endpoint_command_unit usb_cmd_unit_chk #(
   .NUM_EP(NUM_EP), .EP_W(EP_W), .SUSPEND_CYCLES(SUSPEND_CYCLES)
) i_usb_cmd_unit_chk (
   .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .data_wr_valid(data_wr_valid),
   .data_rd_req(data_rd_req), .data_rd_req_ready(data_rd_req_ready), .rd_valid(rd_valid),
   .rd_data(rd_data), .rd_ready(rd_ready), .bus_activity(bus_activity), .bus_reset_event(bus_reset_event),
   .rx_ok(rx_ok), .rx_ep(rx_ep), .remote_wakeup(remote_wakeup), .func_address(func_address),
   .func_enable(func_enable), .ep_full(ep_full), .ep_stall(ep_stall), .ep_disable(ep_disable), .ep_nak(ep_nak)
);

//--- verification/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
   input  wire       clock,
   output reg        bus_activity,
   output reg        bus_reset_event,
   output reg        error_valid,
   output reg  [3:0] error_code,
   output reg        new_transfer,
   output reg        rx_ok,
   output reg  [2:0] rx_ep,
   output reg        rx_setup,
   output reg        tx_ack,
   output reg  [2:0] tx_ep
);
   initial begin
      {bus_activity, bus_reset_event, error_valid, error_code, new_transfer} = 8'h00;
      {rx_ok, rx_ep, rx_setup, tx_ack, tx_ep} = 9'h000;
   end
   // One bus event per call; released fields show the inverse of the last value
   task ev(input [3:0] kind, input [3:0] val, input [2:0] ep);
      begin
         @(posedge clock);
         #1 bus_activity = 1'b1;
         bus_reset_event = (kind == 4'h1);
         error_valid = (kind == 4'h2);
         error_code = val;
         new_transfer = (kind == 4'h3);
         rx_ok = (kind == 4'h4);
         rx_ep = ep;
         rx_setup = val[0];
         tx_ack = (kind == 4'h5);
         tx_ep = ep;
         @(posedge clock);
         #1 {bus_activity, bus_reset_event, error_valid, new_transfer, rx_ok, tx_ack} = 6'h00;
         error_code = ~val;
         rx_ep = ~ep;
         rx_setup = ~val[0];
         tx_ep = ~ep;
      end
   endtask
endmodule
